// ### logic/ecst_tracker.sv
// Context status tracker for floating-point, vector and extra units.
//
// Operation
// R1 - Writable FP and vector fields, read-only summary.
// R2 - Encoding zero Off, one Initial, two Clean, three Dirty.
// R3 - FP field covers all FP registers, CSRs.
// R4 - Vector field covers all vector registers, CSRs.
// R5 - FP field writable when FP hardware present.
// R6 - Vector field writable when vector registers present.
// R7 - No extensions means summary reads zero.
// R8 - Summary is highest extension status value.
// R9 - Dirty bit set when any field Dirty.
// R10 - Off unit access raises illegal instruction.
// R11 - Instruction execution updates fields, any privilege.
// R12 - FP field writes never touch FP registers.
// R13 - Vector field writes never touch vector registers.
// R14 - Untracked FP dirtiness stores Dirty for Initial/Clean.
// R15 - Value-preserving FP write may set Dirty.
// R16 - Vector dirtiness may be tracked imprecisely too.
// R17 - Software saves only Dirty units, then Clean.
// R18 - Software restores Clean from memory, Initial constant.
// R19 - Software sets FP field; summary via extensions.
// R20 - Disabled unit traps until turned back on.
// R21 - Standard units have no enable or disable.
// R22 - One shared copy for all privilege modes.
// R23 - Modifying instruction sets Dirty on retire.
`timescale 1ns/1ps
`default_nettype none

module ecst_tracker #(
	parameter bit HAS_FP = 1'b1,
	parameter bit HAS_VEC = 1'b1,
	parameter bit HAS_SMODE = 1'b1,
	parameter bit HAS_EXT = 1'b1,
	parameter bit FP_PRECISE = 1'b1,
	parameter bit VEC_PRECISE = 1'b1,
	parameter bit DIRTY_ON_SAME = 1'b0
)
(
	input wire logic clk,
	input wire logic reset_n,
	input wire ecst_pkg::ecst_bus_s bus,
	output logic [31:0] rdata,
	input wire logic retire,
	input wire ecst_pkg::ecst_use_s fp_use,
	input wire ecst_pkg::ecst_use_s vec_use,
	input wire ecst_pkg::ecst_use_s [1:0] ext_use,
	input wire logic [1:0] ext_disable,
	input wire logic [1:0] ext_enable,
	input wire logic [1:0] ext_unconfig,
	output logic fp_illegal,
	output logic vec_illegal,
	output logic ext_illegal,
	output logic ext_init_req,
	output logic [1:0] fp_state_status,
	output logic [1:0] vector_state_status,
	output logic [1:0] ext_state_summary,
	output logic dirty_summary_bit
);

	localparam bit FP_LIVE = HAS_FP || HAS_SMODE;
	localparam bit VEC_LIVE = HAS_VEC || HAS_SMODE;

	logic [1:0] fs_r;
	logic [1:0] vs_r;
	logic [1:0] xs_r [2];
	logic [1:0] xs_max;
	logic [31:0] rdata_r;
	logic init_r;

	// Legalises a software write; untracked dirtiness folds Initial/Clean.
	function automatic logic [1:0] ecst_legal(input logic [1:0] v,
		input bit precise);
		if (!precise && (v == 2'h1 || v == 2'h2))
			ecst_legal = 2'h3; // see R14 see R16
		else
			ecst_legal = v; // see R2
	endfunction : ecst_legal

	// Next status from execution; a changing modify, or any modify when same_dirty is set, moves Initial or Clean to Dirty.
	function automatic logic [1:0] ecst_exec(input logic [1:0] cur,
		input ecst_pkg::ecst_use_s u, input bit same_dirty);
		ecst_exec = cur;
		if (u.modify && cur != 2'h0 && (u.changed || same_dirty))
			ecst_exec = 2'h3; // see R23 see R15
	endfunction : ecst_exec

	// Builds the status word; summary and dirty bits are read-only.
	function automatic logic [31:0] ecst_word(input logic [1:0] fs,
		input logic [1:0] vs, input logic [1:0] xs, input logic sd);
		ecst_word = 32'h0;
		ecst_word[ecst_pkg::ECST_FS_LSB +: 2] = fs; // see R2
		ecst_word[ecst_pkg::ECST_VS_LSB +: 2] = vs;
		ecst_word[ecst_pkg::ECST_XS_LSB +: 2] = xs;
		ecst_word[ecst_pkg::ECST_SD_BIT] = sd; // see R9
	endfunction : ecst_word

	logic sw_status;
	assign sw_status = bus.wr && bus.addr == ecst_pkg::ECST_ADDR_STATUS;

	// One shared copy serves every privilege mode; software write wins.
	always_ff @(posedge clk)
	begin
		if (!reset_n)
			fs_r <= ecst_pkg::ECST_FS_RESET;
		else if (!FP_LIVE)
			fs_r <= 2'h0; // see R5
		else if (sw_status)
			fs_r <= ecst_legal(bus.wdata[ecst_pkg::ECST_FS_LSB +: 2],
				FP_PRECISE); // see R19 see R22 see R1
		else if (retire)
			fs_r <= ecst_exec(fs_r, fp_use, DIRTY_ON_SAME); // see R11
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n)
			vs_r <= ecst_pkg::ECST_VS_RESET;
		else if (!VEC_LIVE)
			vs_r <= 2'h0; // see R6
		else if (sw_status)
			vs_r <= ecst_legal(bus.wdata[ecst_pkg::ECST_VS_LSB +: 2],
				VEC_PRECISE); // see R1
		else if (retire)
			vs_r <= ecst_exec(vs_r, vec_use, DIRTY_ON_SAME); // see R11
	end

	// Extension units; only these may disable, enable or unconfigure.
	// Status writes touch no data storage here, so state survives Off.
	for (genvar i = 0; i < ecst_pkg::ECST_NUM_EXT; i++)
	begin : g_ext
		logic [3:0] my_addr;
		assign my_addr = (i == 0) ? ecst_pkg::ECST_ADDR_EXT0
			: ecst_pkg::ECST_ADDR_EXT1;
		always_ff @(posedge clk)
		begin
			if (!reset_n)
				xs_r[i] <= ecst_pkg::ECST_XS_RESET;
			else if (!HAS_EXT)
				xs_r[i] <= 2'h0; // see R7
			else if (bus.wr && bus.addr == my_addr)
				xs_r[i] <= bus.wdata[1:0]; // see R19
			else if (retire && ext_disable[i])
				xs_r[i] <= 2'h0; // see R20
			else if (retire && ext_enable[i])
				xs_r[i] <= 2'h1; // see R20
			else if (retire && ext_unconfig[i] && xs_r[i] != 2'h0)
				xs_r[i] <= 2'h1; // see R21
			else if (retire)
				xs_r[i] <= ecst_exec(xs_r[i], ext_use[i], 1'b1);
		end
	end

	always_comb
	begin
		xs_max = (xs_r[0] > xs_r[1]) ? xs_r[0] : xs_r[1]; // see R8
	end

	// Illegal-instruction flags are combinational so the trap lands in
	// the same cycle as the offending instruction.
	assign fp_illegal = fp_use.access && fs_r == 2'h0; // see R10 see R3
	assign vec_illegal = vec_use.access && vs_r == 2'h0; // see R10 see R4
	assign ext_illegal = (ext_use[0].access && xs_r[0] == 2'h0)
		|| (ext_use[1].access && xs_r[1] == 2'h0); // see R10 see R20

	// Enable forces the extension to reload an initial state.
	always_ff @(posedge clk)
	begin
		if (!reset_n)
			init_r <= 1'b0;
		else
			init_r <= retire && |ext_enable; // see R20
	end
	assign ext_init_req = init_r;

	assign fp_state_status = fs_r; // see R12
	assign vector_state_status = vs_r; // see R13
	assign ext_state_summary = xs_max;
	assign dirty_summary_bit = (fs_r == 2'h3) || (vs_r == 2'h3)
		|| (xs_max == 2'h3); // see R9

	always_ff @(posedge clk)
	begin
		if (!reset_n)
			rdata_r <= 32'h0;
		else if (bus.rd)
		begin
			unique case (bus.addr)
				ecst_pkg::ECST_ADDR_STATUS:
					rdata_r <= ecst_word(fs_r, vs_r, xs_max, dirty_summary_bit);
				ecst_pkg::ECST_ADDR_EXT0:
					rdata_r <= {30'h0, xs_r[0]};
				ecst_pkg::ECST_ADDR_EXT1:
					rdata_r <= {30'h0, xs_r[1]};
				default:
					rdata_r <= 32'h0;
			endcase
		end
		else
			rdata_r <= 32'h0;
	end
	assign rdata = rdata_r;

	// Decodes used only by the checks; the logic keeps its own.
	logic wr_ext0;
	logic wr_ext1;
	assign wr_ext0 = bus.wr && bus.addr == ecst_pkg::ECST_ADDR_EXT0;
	assign wr_ext1 = bus.wr && bus.addr == ecst_pkg::ECST_ADDR_EXT1;

	sd_track_a: assert property ( // see R9
		@(posedge clk) disable iff (!reset_n)
		dirty_summary_bit == (fs_r == 2'h3 || vs_r == 2'h3
		|| xs_max == 2'h3))
		else $error("dirty summary mismatch");

	// A trap on a live unit would make software spin on a good opcode.
	fp_off_trap_a: assert property ( // see R10
		@(posedge clk) disable iff (!reset_n)
		(fp_use.access && fs_r == 2'h0) |-> fp_illegal)
		else $error("fp access while off not trapped");

	fp_no_trap_a: assert property ( // see R10
		@(posedge clk) disable iff (!reset_n)
		(!fp_use.access || fs_r != 2'h0) |-> !fp_illegal)
		else $error("fp trap without off access");

	vec_off_trap_a: assert property ( // see R10
		@(posedge clk) disable iff (!reset_n)
		(vec_use.access && vs_r == 2'h0) |-> vec_illegal)
		else $error("vector access while off not trapped");

	vec_no_trap_a: assert property ( // see R10
		@(posedge clk) disable iff (!reset_n)
		(!vec_use.access || vs_r != 2'h0) |-> !vec_illegal)
		else $error("vector trap without off access");

	ext1_trap_a: assert property ( // see R10
		@(posedge clk) disable iff (!reset_n)
		(ext_use[1].access && xs_r[1] == 2'h0) |-> ext_illegal)
		else $error("extension access while off not trapped");

	ext_no_trap_a: assert property ( // see R10
		@(posedge clk) disable iff (!reset_n)
		!(ext_use[0].access && xs_r[0] == 2'h0)
		&& !(ext_use[1].access && xs_r[1] == 2'h0) |-> !ext_illegal)
		else $error("extension trap without off access");

	// Execution updates; a software write in the same cycle wins.
	fp_dirty_a: assert property ( // see R23
		@(posedge clk) disable iff (!reset_n)
		(retire && !sw_status && fp_use.modify && fp_use.changed
		&& fs_r != 2'h0)
		|=> fs_r == 2'h3)
		else $error("fp modify did not set dirty");

	vec_dirty_a: assert property ( // see R23
		@(posedge clk) disable iff (!reset_n)
		(retire && !sw_status && vec_use.modify && vec_use.changed
		&& vs_r != 2'h0)
		|=> vs_r == 2'h3)
		else $error("vector modify did not set dirty");

	fp_same_a: assert property ( // see R15
		@(posedge clk) disable iff (!reset_n)
		(retire && !sw_status && fp_use.modify && !fp_use.changed
		&& !DIRTY_ON_SAME)
		|=> fs_r == $past(fs_r))
		else $error("fp status moved on unchanged write");

	vec_same_a: assert property ( // see R16
		@(posedge clk) disable iff (!reset_n)
		(retire && !sw_status && vec_use.modify && !vec_use.changed
		&& !DIRTY_ON_SAME)
		|=> vs_r == $past(vs_r))
		else $error("vector status moved on unchanged write");

	fs_hold_a: assert property ( // see R11
		@(posedge clk) disable iff (!reset_n)
		(!sw_status && !(retire && fp_use.modify))
		|=> fs_r == $past(fs_r))
		else $error("fp status changed without cause");

	vs_hold_a: assert property ( // see R11
		@(posedge clk) disable iff (!reset_n)
		(!sw_status && !(retire && vec_use.modify))
		|=> vs_r == $past(vs_r))
		else $error("vector status changed without cause");

	fs_write_a: assert property ( // see R1
		@(posedge clk) disable iff (!reset_n)
		sw_status |=> fs_r == ecst_legal(
		$past(bus.wdata[ecst_pkg::ECST_FS_LSB +: 2]), FP_PRECISE))
		else $error("fp status write not stored");

	vs_write_a: assert property ( // see R1
		@(posedge clk) disable iff (!reset_n)
		sw_status |=> vs_r == ecst_legal(
		$past(bus.wdata[ecst_pkg::ECST_VS_LSB +: 2]), VEC_PRECISE))
		else $error("vector status write not stored");

	xs_max_a: assert property ( // see R8
		@(posedge clk) disable iff (!reset_n)
		xs_max >= xs_r[0] && xs_max >= xs_r[1]
		&& (xs_max == xs_r[0] || xs_max == xs_r[1]))
		else $error("summary not the maximum");

	xs_write0_a: assert property ( // see R19
		@(posedge clk) disable iff (!reset_n)
		wr_ext0 |=> xs_r[0] == $past(bus.wdata[1:0]))
		else $error("extension 0 status write not stored");

	xs_write1_a: assert property ( // see R19
		@(posedge clk) disable iff (!reset_n)
		wr_ext1 |=> xs_r[1] == $past(bus.wdata[1:0]))
		else $error("extension 1 status write not stored");

	ext_off_a: assert property ( // see R20
		@(posedge clk) disable iff (!reset_n)
		(retire && ext_disable[0] && !wr_ext0) |=> xs_r[0] == 2'h0
		&& (!ext_use[0].access || ext_illegal))
		else $error("disabled extension not off");

	ext1_off_a: assert property ( // see R20
		@(posedge clk) disable iff (!reset_n)
		(retire && ext_disable[1] && !wr_ext1) |=> xs_r[1] == 2'h0)
		else $error("disabled extension 1 not off");

	ext_on_a: assert property ( // see R20
		@(posedge clk) disable iff (!reset_n)
		(retire && ext_enable[0] && !ext_disable[0] && !wr_ext0)
		|=> xs_r[0] == 2'h1 && ext_init_req)
		else $error("enabled extension not initial");

	ext_unconf_a: assert property ( // see R21
		@(posedge clk) disable iff (!reset_n)
		(retire && ext_unconfig[1] && !ext_disable[1] && !ext_enable[1]
		&& !wr_ext1 && xs_r[1] != 2'h0)
		|=> xs_r[1] == 2'h1)
		else $error("unconfigured extension not initial");

	rd_data_a: assert property ( // see R1
		@(posedge clk) disable iff (!reset_n)
		!$past(bus.rd) |-> rdata == 32'h0)
		else $error("read data outside answer cycle");

	rd_status_a: assert property ( // see R2
		@(posedge clk) disable iff (!reset_n)
		$past(bus.rd && bus.addr == ecst_pkg::ECST_ADDR_STATUS)
		|-> rdata == ecst_word($past(fs_r), $past(vs_r), $past(xs_max),
		$past(dirty_summary_bit)))
		else $error("status read data wrong");

	rd_ext1_a: assert property ( // see R19
		@(posedge clk) disable iff (!reset_n)
		$past(bus.rd && bus.addr == ecst_pkg::ECST_ADDR_EXT1)
		|-> rdata == {30'h0, $past(xs_r[1])})
		else $error("extension 1 read data wrong");

	fp_dirty_c: cover property (@(posedge clk) disable iff (!reset_n)
		fs_r == 2'h2 ##1 fs_r == 2'h3);
	sd_set_c: cover property (@(posedge clk) disable iff (!reset_n)
		dirty_summary_bit);
	trap_c: cover property (@(posedge clk) disable iff (!reset_n)
		fp_illegal || vec_illegal || ext_illegal);
	ext_on_c: cover property (@(posedge clk) disable iff (!reset_n)
		ext_init_req);
	unconf_c: cover property (@(posedge clk) disable iff (!reset_n)
		xs_r[1] == 2'h3 ##1 xs_r[1] == 2'h1);

endmodule : ecst_tracker

`default_nettype wire

// ### logic/ecst_pkg.sv
// Package with constants and types for the extension context status tracker.
package ecst_pkg;

	localparam int ECST_NUM_EXT = 2;
	localparam int ECST_ST_W = 2;

	typedef enum logic [1:0]
	{
		ECST_OFF = 2'h0,
		ECST_INITIAL = 2'h1,
		ECST_CLEAN = 2'h2,
		ECST_DIRTY = 2'h3
	} ecst_status_e;

	localparam logic [1:0] ECST_FS_RESET = 2'h0;
	localparam logic [1:0] ECST_VS_RESET = 2'h0;
	localparam logic [1:0] ECST_XS_RESET = 2'h0;

	localparam logic [3:0] ECST_ADDR_STATUS = 4'h0;
	localparam logic [3:0] ECST_ADDR_EXT0 = 4'h1;
	localparam logic [3:0] ECST_ADDR_EXT1 = 4'h2;

	localparam int ECST_FS_LSB = 0;
	localparam int ECST_VS_LSB = 2;
	localparam int ECST_XS_LSB = 4;
	localparam int ECST_SD_BIT = 31;

	typedef struct packed
	{
		logic access;
		logic modify;
		logic changed;
	} ecst_use_s;

	typedef struct packed
	{
		logic wr;
		logic rd;
		logic [3:0] addr;
		logic [31:0] wdata;
	} ecst_bus_s;

endpackage : ecst_pkg

// ### verif/ecst_tracker_tb_top.sv
// Self-checking bench for the extension context status tracker.
`timescale 1ns/1ps
`default_nettype none

module ecst_tracker_tb_top;

	localparam ecst_pkg::ecst_use_s u_none = 3'h0;
	localparam ecst_pkg::ecst_use_s u_acc = 3'h4;
	localparam ecst_pkg::ecst_use_s u_same = 3'h6;
	localparam ecst_pkg::ecst_use_s u_chg = 3'h7;

	logic clk = 1'b0;
	logic reset_n = 1'b0;
	ecst_pkg::ecst_bus_s bus = '0;
	logic [31:0] rdata;
	logic retire = 1'b0;
	ecst_pkg::ecst_use_s fp_use = '0;
	ecst_pkg::ecst_use_s vec_use = '0;
	ecst_pkg::ecst_use_s [1:0] ext_use = '0;
	logic [1:0] ext_disable = 2'h0;
	logic [1:0] ext_enable = 2'h0;
	logic [1:0] ext_unconfig = 2'h0;
	logic fp_illegal;
	logic vec_illegal;
	logic ext_illegal;
	logic ext_init_req;
	logic [1:0] fp_state_status;
	logic [1:0] vector_state_status;
	logic [1:0] ext_state_summary;
	logic dirty_summary_bit;
	int num_errors = 0;
	int comparisons = 0;

	always #2 clk = ~clk;

	ecst_tracker uut (
		.clk(clk),
		.reset_n(reset_n),
		.bus(bus),
		.rdata(rdata),
		.retire(retire),
		.fp_use(fp_use),
		.vec_use(vec_use),
		.ext_use(ext_use),
		.ext_disable(ext_disable),
		.ext_enable(ext_enable),
		.ext_unconfig(ext_unconfig),
		.fp_illegal(fp_illegal),
		.vec_illegal(vec_illegal),
		.ext_illegal(ext_illegal),
		.ext_init_req(ext_init_req),
		.fp_state_status(fp_state_status),
		.vector_state_status(vector_state_status),
		.ext_state_summary(ext_state_summary),
		.dirty_summary_bit(dirty_summary_bit)
	);

	task automatic end_sim();
		$display("Comparisons %0d, mismatches %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : end_sim

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	// The status word as the field outputs show it, to compare with reads.
	function automatic logic [31:0] stat();
		return {dirty_summary_bit, 25'h0, ext_state_summary,
			vector_state_status, fp_state_status};
	endfunction : stat

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		bus.wr <= 1'b1;
		bus.addr <= a;
		bus.wdata <= d;
		@(posedge clk);
		bus.wr <= 1'b0;
		#1;
	endtask : wr

	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		@(posedge clk);
		bus.rd <= 1'b1;
		bus.addr <= a;
		@(posedge clk);
		bus.rd <= 1'b0;
		#1;
		chk(rdata, e);
	endtask : rd

	// One retiring instruction; the illegal flags are looked at 1ns after the clock edge, a quarter of the cycle.
	task automatic step(input ecst_pkg::ecst_use_s f, v, x0, x1,
		input logic [1:0] dis, en, unc, input logic [2:0] ill);
		@(posedge clk);
		retire <= 1'b1;
		fp_use <= f;
		vec_use <= v;
		ext_use <= {x1, x0};
		ext_disable <= dis;
		ext_enable <= en;
		ext_unconfig <= unc;
		#1;
		chk({29'h0, fp_illegal, vec_illegal, ext_illegal}, {29'h0, ill});
		@(posedge clk);
		retire <= 1'b0;
		fp_use <= u_none;
		vec_use <= u_none;
		ext_use <= '0;
		ext_disable <= 2'h0;
		ext_enable <= 2'h0;
		ext_unconfig <= 2'h0;
		#1;
	endtask : step

	// A hang would leave the verdict unprinted, so the run is capped.
	initial
	begin
		repeat (5000) @(posedge clk);
		num_errors++;
		end_sim();
	end

	initial
	begin
		repeat (20) @(posedge clk);
		reset_n <= 1'b1;
		rd(4'h0, 32'h0);
		step(u_acc, u_acc, u_acc, u_none, 2'h0, 2'h0, 2'h0, 3'h7);
		for (int i = 0; i < 4; i++)
		begin
			wr(4'h0, 32'(i * 5));
			rd(4'h0, 32'(i * 5) | (i == 3 ? 32'h8000_0000 : 32'h0));
		end
		wr(4'h0, 32'hffff_ffff);
		rd(4'h0, 32'h8000_000f);
		wr(4'h0, 32'h9);
		step(u_same, u_acc, u_none, u_none, 2'h0, 2'h0, 2'h0, 3'h0);
		chk(stat(), 32'h9);
		step(u_chg, u_chg, u_none, u_none, 2'h0, 2'h0, 2'h0, 3'h0);
		chk(stat(), 32'h8000_000f);
		wr(4'h0, 32'ha);
		rd(4'h0, 32'ha);
		wr(4'h0, 32'h1);
		rd(4'h0, 32'h1);
		wr(4'h0, 32'h0);
		wr(4'h1, 32'h2);
		wr(4'h2, 32'h1);
		chk(stat(), 32'h20);
		wr(4'h2, 32'h3);
		rd(4'h0, 32'h8000_0030);
		step(u_none, u_none, u_none, u_none, 2'h1, 2'h0, 2'h0, 3'h0);
		rd(4'h1, 32'h0);
		step(u_none, u_none, u_acc, u_none, 2'h0, 2'h0, 2'h0, 3'h1);
		step(u_none, u_none, u_none, u_none, 2'h0, 2'h1, 2'h0, 3'h0);
		chk({31'h0, ext_init_req}, 32'h1);
		rd(4'h1, 32'h1);
		chk({31'h0, ext_init_req}, 32'h0);
		step(u_none, u_none, u_none, u_none, 2'h0, 2'h0, 2'h2, 3'h0);
		chk(stat(), 32'h10);
		step(u_none, u_none, u_none, u_chg, 2'h0, 2'h0, 2'h0, 3'h0);
		chk(stat(), 32'h8000_0030);
		rd(4'h5, 32'h0);
		wr(4'h7, 32'hffff_ffff);
		rd(4'h0, 32'h8000_0030);
		end_sim();
	end

endmodule : ecst_tracker_tb_top

`default_nettype wire
